// File: rtl/dtp_timing_regs.sv
// Purpose: DRAM timing registers with AXI4-Lite access and the gap checks they steer
// Assumes: Scheduler strobes are one-cycle pulses on aclk, issued only when allowed
// Notes:   Gap outputs only advise; only self-refresh exit is held back here, until the minimum
// Contract
// - Space mode register writes by programmed count
// - Auto-precharge writes apply write recovery plus precharge
// - Hold clock enable low self-refresh minimum
// - Space column commands by CAS-to-CAS delay
// - Same-bank activates spaced by row cycle time
// - Enforce four-activate window on activates
// - Record out-of-range command type, read-only
// - Write recovery before precharge to same bank
`include "dtp_defines.svh"
`default_nettype none

module dtp_timing_regs (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [`DTP_ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [`DTP_ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          auto_precharge_enable,
    input  wire logic                          mrw_issue,
    input  wire logic                          col_issue,
    input  wire logic                          act_issue,
    input  wire logic [2:0]                    act_bank,
    input  wire logic                          wr_burst_end,
    input  wire logic [2:0]                    wr_bank,
    input  wire logic                          sr_enter,
    input  wire logic                          sr_exit_req,
    input  wire logic                          oor_event,
    input  wire logic [5:0]                    oor_cmd_type,
    output logic                               mrw_allowed,
    output logic                               col_allowed,
    output logic [`DTP_NUM_BANKS-1:0]          act_allowed,
    output logic [`DTP_NUM_BANKS-1:0]          pre_allowed,
    output logic                               dram_cke
);

    dtp_pkg::dtp_regs_state_type state_reg;
    dtp_pkg::dtp_regs_state_type state_next;

    logic [`DTP_GAP_W-1:0]      mrd_gap;
    logic [`DTP_GAP_W-1:0]      dal_gap;
    logic [`DTP_GAP_W-1:0]      ckesr_gap;
    logic [`DTP_GAP_W-1:0]      ccd_gap;
    logic [`DTP_GAP_W-1:0]      trc_gap;
    logic [`DTP_GAP_W-1:0]      faw_gap;
    logic [`DTP_GAP_W-1:0]      twr_gap;
    logic                       ckesr_ready;
    logic [`DTP_NUM_BANKS-1:0]  trc_ready;
    logic [`DTP_NUM_BANKS-1:0]  dal_ready;
    logic [`DTP_NUM_BANKS-1:0]  twr_ready;
    logic [`DTP_FAW_SLOTS-1:0]  faw_ready;
    logic                       faw_ok;
    logic                       aw_take;
    logic                       w_take;
    logic                       aw_have;
    logic                       w_have;
    logic [`DTP_ADDR_W-1:0]     wr_addr;
    logic [31:0]                wr_data;
    logic [3:0]                 wr_strb;
    logic                       ar_take;

    // Field extraction; 5-bit fields zero-extended to the timer width
    assign mrd_gap   = {1'b0, state_reg.timing_a[`DTP_MRD_LSB +: 5]};
    assign dal_gap   = {1'b0, state_reg.timing_a[`DTP_DAL_LSB +: 5]};
    assign ckesr_gap = {1'b0, state_reg.timing_a[`DTP_CKESR_LSB +: 5]};
    assign ccd_gap   = {1'b0, state_reg.timing_a[`DTP_CCD_LSB +: 5]};
    assign trc_gap   = state_reg.timing_b[`DTP_TRC_LSB +: 6];
    assign faw_gap   = state_reg.timing_b[`DTP_FAW_LSB +: 6];
    assign twr_gap   = {1'b0, state_reg.timing_b[`DTP_TWR_LSB +: 5]};

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb,
        input logic [31:0] wmask
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        // Bits outside the mask keep their value: reserved and read-only
        merge_bytes = (res & wmask) | (old_val & ~wmask);
    endfunction

    // Write address and data are taken independently, in either order
    assign s_axi_awready = !state_reg.aw_held && (state_reg.wst == dtp_pkg::DTP_WR_COLLECT);
    assign s_axi_wready  = !state_reg.w_held && (state_reg.wst == dtp_pkg::DTP_WR_COLLECT);
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign aw_have       = state_reg.aw_held || aw_take;
    assign w_have        = state_reg.w_held || w_take;
    assign wr_addr       = state_reg.aw_held ? state_reg.awaddr : s_axi_awaddr;
    assign wr_data       = state_reg.w_held ? state_reg.wdata : s_axi_wdata;
    assign wr_strb       = state_reg.w_held ? state_reg.wstrb : s_axi_wstrb;
    assign s_axi_bvalid  = (state_reg.wst == dtp_pkg::DTP_WR_RESP);
    assign s_axi_bresp   = state_reg.bresp;

    // One read outstanding; the next address waits until the data is taken
    assign s_axi_arready = !state_reg.rvalid;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rdata   = state_reg.rdata;
    assign s_axi_rresp   = state_reg.rresp;

    // Oldest slot of the window must have expired before a fifth activate
    assign faw_ok = faw_ready[state_reg.faw_ptr];

    always_comb begin
        state_next = state_reg;

        unique case (state_reg.wst)
            dtp_pkg::DTP_WR_COLLECT: begin
                if (aw_have && w_have) begin
                    state_next.aw_held = 1'b0;
                    state_next.w_held  = 1'b0;
                    state_next.wst     = dtp_pkg::DTP_WR_RESP;
                    state_next.bresp   = `DTP_RESP_OKAY;
                    if (wr_addr == `DTP_OFF_TIMING_A) begin
                        state_next.timing_a = merge_bytes(state_reg.timing_a, wr_data,
                                                          wr_strb, `DTP_TIMING_A_WMASK);
                    end else if (wr_addr == `DTP_OFF_TIMING_B) begin
                        state_next.timing_b = merge_bytes(state_reg.timing_b, wr_data,
                                                          wr_strb, `DTP_TIMING_B_WMASK);
                    end else begin
                        state_next.bresp = `DTP_RESP_SLVERR;
                    end
                end else begin
                    if (aw_take) begin
                        state_next.aw_held = 1'b1;
                        state_next.awaddr  = s_axi_awaddr;
                    end
                    if (w_take) begin
                        state_next.w_held = 1'b1;
                        state_next.wdata  = s_axi_wdata;
                        state_next.wstrb  = s_axi_wstrb;
                    end
                end
            end
            dtp_pkg::DTP_WR_RESP: begin
                if (s_axi_bready) begin
                    state_next.wst = dtp_pkg::DTP_WR_COLLECT;
                end
            end
            default: begin
                state_next.wst = dtp_pkg::DTP_WR_COLLECT;
            end
        endcase

        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (ar_take) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = `DTP_RESP_OKAY;
            if (s_axi_araddr == `DTP_OFF_TIMING_A) begin
                state_next.rdata = state_reg.timing_a & `DTP_TIMING_A_WMASK;
            end else if (s_axi_araddr == `DTP_OFF_TIMING_B) begin
                state_next.rdata = state_reg.timing_b & `DTP_TIMING_B_RMASK;
            end else begin
                state_next.rdata = 32'h00000000;
                state_next.rresp = `DTP_RESP_SLVERR;
            end
        end

        // Hardware-only field; software writes are masked off above
        if (oor_event) begin
            state_next.timing_b[`DTP_OOR_LSB +: 6] = oor_cmd_type;
        end

        // Self-refresh: drop clock enable, release only after the minimum
        if (sr_enter && !state_reg.in_sr) begin
            state_next.in_sr = 1'b1;
            state_next.cke   = 1'b0;
        end else if (state_reg.in_sr && sr_exit_req && ckesr_ready) begin
            state_next.in_sr = 1'b0;
            state_next.cke   = 1'b1;
        end

        if (act_issue) begin
            state_next.faw_ptr = state_reg.faw_ptr + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg.timing_a <= `DTP_TIMING_A_RESET;
            state_reg.timing_b <= `DTP_TIMING_B_RESET;
            state_reg.aw_held  <= 1'b0;
            state_reg.awaddr   <= '0;
            state_reg.w_held   <= 1'b0;
            state_reg.wdata    <= 32'h00000000;
            state_reg.wstrb    <= 4'h0;
            state_reg.wst      <= dtp_pkg::DTP_WR_COLLECT;
            state_reg.bresp    <= `DTP_RESP_OKAY;
            state_reg.rvalid   <= 1'b0;
            state_reg.rdata    <= 32'h00000000;
            state_reg.rresp    <= `DTP_RESP_OKAY;
            state_reg.cke      <= `DTP_CKE_RESET;
            state_reg.in_sr    <= 1'b0;
            state_reg.faw_ptr  <= `DTP_FAW_PTR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dram_cke = state_reg.cke;

    dtp_gap_timer u_mrd (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (mrw_issue),
        .gap     (mrd_gap),
        .ready   (mrw_allowed)
    );

    dtp_gap_timer u_ccd (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (col_issue),
        .gap     (ccd_gap),
        .ready   (col_allowed)
    );

    dtp_gap_timer u_ckesr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (sr_enter && !state_reg.in_sr),
        .gap     (ckesr_gap),
        .ready   (ckesr_ready)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `DTP_NUM_BANKS; gi++) begin : g_bank
            dtp_gap_timer u_trc (
                .aclk    (aclk),
                .aresetn (aresetn),
                .load    (act_issue && (act_bank == 3'(gi))),
                .gap     (trc_gap),
                .ready   (trc_ready[gi])
            );

            // Auto precharge closes the row itself; next activate waits the full sum
            dtp_gap_timer u_dal (
                .aclk    (aclk),
                .aresetn (aresetn),
                .load    (wr_burst_end && auto_precharge_enable && (wr_bank == 3'(gi))),
                .gap     (dal_gap),
                .ready   (dal_ready[gi])
            );

            dtp_gap_timer u_twr (
                .aclk    (aclk),
                .aresetn (aresetn),
                .load    (wr_burst_end && (wr_bank == 3'(gi))),
                .gap     (twr_gap),
                .ready   (twr_ready[gi])
            );

            assign act_allowed[gi] = trc_ready[gi] && dal_ready[gi] && faw_ok;
            assign pre_allowed[gi] = twr_ready[gi];
        end

        for (gi = 0; gi < `DTP_FAW_SLOTS; gi++) begin : g_faw
            dtp_gap_timer u_faw (
                .aclk    (aclk),
                .aresetn (aresetn),
                .load    (act_issue && (state_reg.faw_ptr == 2'(gi))),
                .gap     (faw_gap),
                .ready   (faw_ready[gi])
            );
        end
    endgenerate

endmodule

`default_nettype wire

// File: rtl/dtp_defines.svh
// Purpose: Offsets, field positions, masks and reset values of the timing registers
// Assumes: 8-bit byte address on the register bus, 32-bit data
// Notes:   Definitions only
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH

`define DTP_ADDR_W           8
`define DTP_OFF_TIMING_A     8'h94
`define DTP_OFF_TIMING_B     8'h98

`define DTP_MRD_LSB          24
`define DTP_DAL_LSB          16
`define DTP_CKESR_LSB        8
`define DTP_CCD_LSB          0
`define DTP_TRC_LSB          24
`define DTP_FAW_LSB          16
`define DTP_OOR_LSB          8
`define DTP_TWR_LSB          0

`define DTP_TIMING_A_WMASK   32'h1f1f1f1f
`define DTP_TIMING_B_WMASK   32'h3f3f001f
`define DTP_TIMING_B_RMASK   32'h3f3f3f1f
`define DTP_TIMING_A_RESET   32'h00000000
`define DTP_TIMING_B_RESET   32'h00000000
`define DTP_CKE_RESET        1'b1
`define DTP_FAW_PTR_RESET    2'h0

`define DTP_NUM_BANKS        8
`define DTP_FAW_SLOTS        4
`define DTP_GAP_W            6

`define DTP_RESP_OKAY        2'h0
`define DTP_RESP_SLVERR      2'h2

`endif

// File: rtl/dtp_pkg.sv
// Purpose: Types shared by the timing register block and its gap timers
// Assumes: Constants live in dtp_defines.svh
// Notes:   One packed state struct per module
`include "dtp_defines.svh"
`default_nettype none

package dtp_pkg;

    typedef enum logic [1:0] {
        DTP_WR_COLLECT = 2'b01,
        DTP_WR_RESP    = 2'b10
    } dtp_wr_state_type;

    typedef struct packed {
        logic [`DTP_GAP_W-1:0] cnt;
    } dtp_timer_state_type;

    typedef struct packed {
        logic [31:0]              timing_a;
        logic [31:0]              timing_b;
        logic                     aw_held;
        logic [`DTP_ADDR_W-1:0]   awaddr;
        logic                     w_held;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        dtp_wr_state_type         wst;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
        logic                     cke;
        logic                     in_sr;
        logic [1:0]               faw_ptr;
    } dtp_regs_state_type;

endpackage

`default_nettype wire

// File: rtl/dtp_gap_timer.sv
// Purpose: Least-gap timer; ready is high once gap cycles have passed since load
// Assumes: load is a one-cycle pulse from logic on aclk
// Notes:   A gap of 0 or 1 leaves ready high in the cycle after load
`include "dtp_defines.svh"
`default_nettype none

module dtp_gap_timer (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  load,
    input  wire logic [`DTP_GAP_W-1:0] gap,
    output logic                       ready
);

    dtp_pkg::dtp_timer_state_type state_reg;
    dtp_pkg::dtp_timer_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (load) begin
            // Load gap-1 so the next event may issue exactly gap cycles later
            state_next.cnt = (gap == '0) ? '0 : gap - `DTP_GAP_W'(1);
        end else if (state_reg.cnt != '0) begin
            state_next.cnt = state_reg.cnt - `DTP_GAP_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg.cnt <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ready = (state_reg.cnt == '0);

endmodule

`default_nettype wire

// File: dv/dtp_timing_regs_props.sv
// Purpose: Port assertions for dtp_timing_regs
// Assumes: Bound to the top module, sync active-low reset
// Notes:   Gap lengths need register values, so the bench measures them
`default_nettype none
module dtp_timing_regs_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        mrw_issue,
    input wire logic        col_issue,
    input wire logic        act_issue,
    input wire logic        wr_burst_end,
    input wire logic        sr_enter,
    input wire logic        mrw_allowed,
    input wire logic        col_allowed,
    input wire logic [7:0]  act_allowed,
    input wire logic [7:0]  pre_allowed,
    input wire logic        dram_cke
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    mrw_gap_a: assert property ($fell(mrw_allowed) |-> $past(mrw_issue))
        else $error("mode write gap began with no command");
    col_gap_a: assert property ($fell(col_allowed) |-> $past(col_issue))
        else $error("column gap began with no command");
    act_gap_a: assert property (|($past(act_allowed) & ~act_allowed)
        |-> $past(act_issue | wr_burst_end)) else $error("activate block with no cause");
    pre_gap_a: assert property (|($past(pre_allowed) & ~pre_allowed)
        |-> $past(wr_burst_end)) else $error("precharge block with no write");
    cke_drop_a: assert property (sr_enter && dram_cke |=> !dram_cke)
        else $error("clock enable stayed high on self-refresh entry");
    cke_cause_a: assert property ($fell(dram_cke) |-> $past(sr_enter))
        else $error("clock enable fell outside self-refresh entry");
    resv_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hc0c0c0e0) == 32'h0)
        else $error("reserved read bits not zero");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property ($fell(dram_cke));
    cover property ($fell(col_allowed));
endmodule
bind dtp_timing_regs dtp_timing_regs_props u_props (
    .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mrw_issue, .col_issue,
    .act_issue, .wr_burst_end, .sr_enter, .mrw_allowed, .col_allowed, .act_allowed,
    .pre_allowed, .dram_cke
);
`default_nettype wire

// File: dv/dtp_dram_model.sv
// Purpose: Memory-side monitor of the clock-enable pin
// Assumes: Same clock as the controller
// Notes:   Reports the length of the last low run of clock enable
`default_nettype none
module dtp_dram_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       dram_cke,
    output logic      [7:0] cke_low_len
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] run_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_reg <= 8'h00;
            cke_low_len <= 8'h00;
        end else if (!dram_cke) begin
            run_reg <= run_reg + 8'h01;
        end else if (run_reg != 8'h00) begin
            cke_low_len <= run_reg;
            run_reg <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: dv/test_dtp_timing_regs.sv
// Purpose: Self-checking bench for dtp_timing_regs
// Assumes: Bench is AXI4-Lite master and scheduler
// Notes:   Gap counts start in the cycle after the issuing edge
`include "dtp_defines.svh"
`default_nettype none
module test_dtp_timing_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, auto_precharge_enable = 1'b0;
    logic        mrw_issue = 1'b0, col_issue = 1'b0, act_issue = 1'b0, wr_burst_end = 1'b0;
    logic        sr_enter = 1'b0, sr_exit_req = 1'b0, oor_event = 1'b0;
    logic [2:0]  act_bank = 3'h0, wr_bank = 3'h0;
    logic [5:0]  oor_cmd_type = 6'h00;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        mrw_allowed, col_allowed, dram_cke;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    logic [7:0]  act_allowed, pre_allowed, cke_low_len;
    int          n, n_mismatch = 0, check_count = 0;

    dtp_timing_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .auto_precharge_enable, .mrw_issue,
        .col_issue, .act_issue, .act_bank, .wr_burst_end, .wr_bank, .sr_enter, .sr_exit_req,
        .oor_event, .oor_cmd_type, .mrw_allowed, .col_allowed, .act_allowed, .pre_allowed,
        .dram_cke);
    dtp_dram_model u_dram (.aclk, .aresetn, .dram_cke, .cke_low_len);

    initial begin
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Readies sampled at the falling edge: they settle there and hold to the next rise
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = pa & s_axi_awready;
            tw = pw & s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (ta) pa = 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tw) pw = 1'b0;
        end while (pa | pw);
        do begin
            @(negedge aclk);
            ta = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end while (!ta);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            t = s_axi_arready;
            @(posedge aclk);
        end while (!t);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end while (!t);
        s_axi_rready <= 1'b0;
    endtask

    task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [31:0] e);
        axw(a, d, s, rs);
        chk(rs, 2'h0);
        axr(a, rd, rs);
        chk(rs, 2'h0);
        chk(rd, e);
    endtask

    function automatic logic ok(input int k, input logic [2:0] b);
        case (k)
            0: return col_allowed;
            1: return mrw_allowed;
            3: return pre_allowed[b];
            default: return act_allowed[b];
        endcase
    endfunction

    // Kinds: 0 column, 1 mode write, 2 activate, 3 write end to precharge, 4 to activate
    task automatic gap(input int k, input logic [2:0] b, output int c);
        col_issue <= (k == 0);
        mrw_issue <= (k == 1);
        act_issue <= (k == 2);
        wr_burst_end <= (k > 2);
        act_bank <= b;
        wr_bank <= b;
        @(posedge aclk);
        {mrw_issue, col_issue, act_issue, wr_burst_end} <= 4'h0;
        c = 1;
        @(negedge aclk);
        while (!ok(k, b) && c < 100) begin
            @(negedge aclk);
            c++;
        end
        @(posedge aclk);
    endtask

    task automatic t_regs;
        axr(`DTP_OFF_TIMING_B, rd, rs);
        chk(rd, 32'h0);
        chk(dram_cke, 1'b1);
        wrrd(`DTP_OFF_TIMING_A, 32'hffffffff, 4'hf, 32'h1f1f1f1f);
        wrrd(`DTP_OFF_TIMING_A, 32'h0, 4'h1, 32'h1f1f1f00);
        wrrd(`DTP_OFF_TIMING_B, 32'hffffffff, 4'hf, 32'h3f3f001f);
        axw(8'h40, 32'hffffffff, 4'hf, rs);
        chk(rs, 2'h2);
        axr(8'h40, rd, rs);
        chk(rd, 32'h0);
        chk(rs, 2'h2);
        oor_cmd_type <= 6'h2a;
        oor_event <= 1'b1;
        @(posedge aclk);
        oor_event <= 1'b0;
        wrrd(`DTP_OFF_TIMING_B, 32'h0, 4'hf, 32'h00002a00);
        $display("test registers done");
    endtask

    task automatic t_gaps;
        auto_precharge_enable <= 1'b1;
        wrrd(`DTP_OFF_TIMING_A, 32'h04050503, 4'hf, 32'h04050503);
        wrrd(`DTP_OFF_TIMING_B, 32'h06000007, 4'hf, 32'h06002a07);
        gap(0, 3'h0, n);
        chk(n, 32'd3);
        gap(1, 3'h0, n);
        chk(n, 32'd4);
        gap(2, 3'h0, n);
        chk(n, 32'd6);
        gap(3, 3'h2, n);
        chk(n, 32'd7);
        gap(4, 3'h1, n);
        chk(n, 32'd5);
        wrrd(`DTP_OFF_TIMING_B, 32'h010a0001, 4'hf, 32'h010a2a01);
        for (int b = 4; b < 7; b++) begin
            act_issue <= 1'b1;
            act_bank <= b[2:0];
            @(posedge aclk);
        end
        gap(2, 3'h7, n);
        chk(n, 32'd7);
        // Without auto precharge a write end must not hold off the next activate
        auto_precharge_enable <= 1'b0;
        gap(4, 3'h3, n);
        chk(n, 32'd1);
        $display("test gaps done");
    endtask

    task automatic t_sr;
        sr_enter <= 1'b1;
        sr_exit_req <= 1'b1;
        @(posedge aclk);
        sr_enter <= 1'b0;
        @(negedge aclk);
        chk(dram_cke, 1'b0);
        for (int i = 0; i < 50 && dram_cke !== 1'b1; i++) @(negedge aclk);
        repeat (2) @(posedge aclk);
        sr_exit_req <= 1'b0;
        chk(cke_low_len >= 8'd5, 1'b1);
        $display("test self-refresh done");
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_gaps;
        t_sr;
        print_verdict;
    end

    initial begin
        repeat (3000) @(posedge aclk);
        n_mismatch++;
        print_verdict;
    end
endmodule
`default_nettype wire
